// ===== src/pcs_params.svh
// Operation
// - PC is 15 bits; low byte readable and writable, upper bits only via latch.
// - Every reset clears the whole program counter.
// - Writing PC low byte loads PC bits 14..8 from the latch together.
// - Adding working register to PC low byte never carries into upper bits.
// - Call loads low 11 bits from operand, bits 14..11 from latch 6..3.
// - Working-register call loads low byte from working, upper from latch.
// - Working branch loads PC with PC plus one plus unsigned working value.
// - Immediate branch loads PC with PC plus one plus signed 9-bit operand (bits 8..0).
// - Return stack holds 16 entries of 15 bits, apart from other memories.
// - Calls and vectoring push; the single return op pops.
// - Push and pop leave the high latch register unchanged.
// - With fault reset disabled, the stack wraps and overwrites oldest entries.
// - Overflow and underflow flags set on every fault, reset enabled or not.
// - With fault reset enabled, over or underflow resets and sets its flag.
// - Stack index register selects the entry shown in the top-of-stack pair.
// - Stack index is five bits wide to detect overflow and underflow.
// - Push increments index then writes; pop reads entry then decrements.
// - Empty index is 0x1F; first push gives 0x00, pop returns 0x1F.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_PC_W 15
`define PCS_IDX_W 5
`define PCS_DEPTH 16
`define PCS_SLOT_W 4
`define PCS_IDX_EMPTY 5'h1F
`define PCS_IDX_LAST 5'h0F
`define PCS_IDX_UNF_WRAP 5'h0E
`define PCS_PC_RESET 15'h0000
`define PCS_VECTOR 15'h0004
`define PCS_IDX_STACK_INDEX 16'h1FED
`define PCS_IDX_TOS_LOW 16'h1FEE
`define PCS_IDX_TOS_HIGH 16'h1FEF
`define PCS_IDX_PC_LOW 16'h1FF0
`define PCS_IDX_PC_LATCH 16'h1FF1
`define PCS_IDX_POWER 16'h1FF2
`define PCS_IDX_CONFIG 16'h1FF3
`define PCS_BIT_UNF 0
`define PCS_BIT_OVF 1
`define PCS_BIT_FAULT_EN 0
`endif

// ===== src/pcs_pkg.sv
package pcs_pkg;
  typedef enum logic [3:0] {
    PCS_OP_NONE,
    PCS_OP_STEP,
    PCS_OP_WRITE_LOW,
    PCS_OP_ADD_LOW,
    PCS_OP_CALL,
    PCS_OP_CALL_VIA_WORKING,
    PCS_OP_BRW,
    PCS_OP_BRA,
    PCS_OP_RET,
    PCS_OP_VECTOR
  } pcs_op_t;
endpackage : pcs_pkg

// ===== src/pcs_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pcs_params.svh"
module pcs_top
  import pcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input pcs_op_t op_kind_i,
  input wire logic [10:0] op_operand_i,
  input wire logic [7:0] op_wreg_i,
  input wire logic [7:0] op_result_i,
  output logic [`PCS_PC_W-1:0] pc_o,
  output logic [`PCS_IDX_W-1:0] stack_index_o,
  output logic fault_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [`PCS_PC_W-1:0] pc_reg;
  logic [`PCS_PC_W-1:0] pc_next;
  logic [`PCS_PC_W-1:0] pc_inc;
  logic [6:0] latch_reg;
  logic [`PCS_IDX_W-1:0] idx_reg;
  logic [`PCS_IDX_W-1:0] idx_next;
  logic fault_en_reg;
  logic ovf_reg;
  logic unf_reg;
  logic fault_reg;
  logic [`PCS_PC_W-1:0] stack_mem [`PCS_DEPTH];
  logic [`PCS_PC_W-1:0] tos_rd;
  logic [`PCS_PC_W-1:0] push_val;
  logic [`PCS_SLOT_W-1:0] push_slot;
  logic do_push;
  logic do_pop;
  logic ovf_evt;
  logic unf_evt;
  logic op_live;
  logic wb_req;
  logic wb_wr;
  logic [15:0] wb_idx;
  logic wb_hit_high;
  logic [31:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Ops are dropped while the fault reset pulse is out
  assign op_live = !fault_reg;
  assign pc_inc = pc_reg + `PCS_PC_W'(1);
  assign tos_rd = stack_mem[idx_reg[`PCS_SLOT_W-1:0]];

  assign do_push = op_live && (op_kind_i == PCS_OP_CALL || op_kind_i == PCS_OP_CALL_VIA_WORKING ||
    op_kind_i == PCS_OP_VECTOR);
  assign do_pop = op_live && op_kind_i == PCS_OP_RET;
  assign ovf_evt = do_push && idx_reg == `PCS_IDX_LAST;
  assign unf_evt = do_pop && idx_reg == `PCS_IDX_EMPTY;
  // Vectoring saves the interrupted address, calls save the next one
  assign push_val = (op_kind_i == PCS_OP_VECTOR) ? pc_reg : pc_inc;

  always_comb begin
    pc_next = pc_reg;
    unique case (op_kind_i)
      PCS_OP_NONE: pc_next = pc_reg;
      PCS_OP_STEP: pc_next = pc_inc;
      PCS_OP_WRITE_LOW: pc_next = {latch_reg, op_result_i};
      PCS_OP_ADD_LOW: pc_next = {latch_reg, 8'(pc_reg[7:0] + op_wreg_i)};
      PCS_OP_CALL: pc_next = {latch_reg[6:3], op_operand_i};
      PCS_OP_CALL_VIA_WORKING: pc_next = {latch_reg, op_wreg_i};
      PCS_OP_BRW: pc_next = `PCS_PC_W'(pc_inc + {7'h00, op_wreg_i});
      PCS_OP_BRA: begin
        pc_next = `PCS_PC_W'(pc_inc + {{6{op_operand_i[8]}}, op_operand_i[8:0]});
      end
      PCS_OP_RET: pc_next = tos_rd;
      PCS_OP_VECTOR: pc_next = `PCS_VECTOR;
      default: pc_next = pc_reg;
    endcase
  end

  always_comb begin
    idx_next = idx_reg;
    if (do_push) begin
      // Wrap keeps the index inside the sixteen live slots
      idx_next = ovf_evt ? 5'h00 : `PCS_IDX_W'(idx_reg + 5'h01);
    end else if (do_pop) begin
      if (unf_evt) begin
        idx_next = `PCS_IDX_UNF_WRAP;
      end else begin
        idx_next = `PCS_IDX_W'(idx_reg - 5'h01);
      end
    end
  end

  assign push_slot = idx_next[`PCS_SLOT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_idx = wb_adr_i[17:2];
  assign wb_hit_high = wb_adr_i[31:18] == 14'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Fault reset: one-cycle pulse, then PC and index return to reset state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_en_reg && (ovf_evt || unf_evt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || fault_reg) begin
      pc_reg <= `PCS_PC_RESET;
    end else if (fault_en_reg && (ovf_evt || unf_evt)) begin
      pc_reg <= pc_reg;
    end else if (op_kind_i != PCS_OP_NONE) begin
      pc_reg <= pc_next;
    end else if (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_PC_LOW) begin
      pc_reg <= {latch_reg, wb_dat_i[7:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || fault_reg) begin
      idx_reg <= `PCS_IDX_EMPTY;
    end else if (fault_en_reg && (ovf_evt || unf_evt)) begin
      idx_reg <= idx_reg;
    end else if (do_push || do_pop) begin
      idx_reg <= idx_next;
    end else if (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_STACK_INDEX) begin
      // Interrupt vectoring also moves this index under software's feet
      idx_reg <= wb_dat_i[`PCS_IDX_W-1:0];
    end
  end

  // Latch is touched only by software, never by push or pop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= 7'h00;
    end else if (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_PC_LATCH) begin
      latch_reg <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_en_reg <= 1'b0;
    end else if (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_CONFIG) begin
      fault_en_reg <= wb_dat_i[`PCS_BIT_FAULT_EN];
    end
  end

  // Sticky flags survive the fault reset; a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else begin
      if (ovf_evt) begin
        ovf_reg <= 1'b1;
      end else if (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_POWER &&
                   wb_dat_i[`PCS_BIT_OVF]) begin
        ovf_reg <= 1'b0;
      end
      if (unf_evt) begin
        unf_reg <= 1'b1;
      end else if (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_POWER &&
                   wb_dat_i[`PCS_BIT_UNF]) begin
        unf_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack slots live in their own flops, outside both memory spaces
  genvar gi;
  generate
    for (gi = 0; gi < `PCS_DEPTH; gi = gi + 1) begin : g_slot
      logic sw_sel;
      assign sw_sel = wb_wr && wb_hit_high && !do_push &&
        idx_reg[`PCS_SLOT_W-1:0] == `PCS_SLOT_W'(gi);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stack_mem[gi] <= `PCS_PC_RESET;
        end else if (do_push && !(fault_en_reg && ovf_evt) &&
                     push_slot == `PCS_SLOT_W'(gi)) begin
          stack_mem[gi] <= push_val;
        end else if (sw_sel && wb_idx == `PCS_IDX_TOS_LOW) begin
          stack_mem[gi] <= {stack_mem[gi][14:8], wb_dat_i[7:0]};
        end else if (sw_sel && wb_idx == `PCS_IDX_TOS_HIGH) begin
          stack_mem[gi] <= {wb_dat_i[6:0], stack_mem[gi][7:0]};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_hit_high) begin
      unique case (wb_idx)
        `PCS_IDX_STACK_INDEX: rd_data = {27'h000_0000, idx_reg};
        `PCS_IDX_TOS_LOW: rd_data = {24'h00_0000, tos_rd[7:0]};
        `PCS_IDX_TOS_HIGH: rd_data = {25'h000_0000, tos_rd[14:8]};
        `PCS_IDX_PC_LOW: rd_data = {24'h00_0000, pc_reg[7:0]};
        `PCS_IDX_PC_LATCH: rd_data = {25'h000_0000, latch_reg};
        `PCS_IDX_POWER: rd_data = {30'h0000_0000, ovf_reg, unf_reg};
        `PCS_IDX_CONFIG: rd_data = {31'h0000_0000, fault_en_reg};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Unmapped words ack with zero; writes there are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  assign pc_o = pc_reg;
  assign stack_index_o = idx_reg;
  assign fault_reset_o = fault_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fault_seq;
    ##1 fault_reset_o ##1 (pc_o == `PCS_PC_RESET && stack_index_o == `PCS_IDX_EMPTY);
  endsequence

  sequence s_wrap_seq;
    ##1 (stack_index_o == 5'h00 && ovf_reg);
  endsequence

  reset_pc_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> pc_o == `PCS_PC_RESET)
    else $error("PC not cleared by reset");

  write_low_a: assert property (op_live && op_kind_i == PCS_OP_WRITE_LOW && !ovf_evt
    |=> pc_o == {$past(latch_reg), $past(op_result_i)})
    else $error("PC low write did not load latch");

  add_carry_a: assert property (op_live && op_kind_i == PCS_OP_ADD_LOW
    |=> pc_o[14:8] == $past(latch_reg))
    else $error("Add to PC low carried upward");

  call_load_a: assert property (op_live && op_kind_i == PCS_OP_CALL && !ovf_evt
    |=> pc_o == {$past(latch_reg[6:3]), $past(op_operand_i)})
    else $error("Call target wrong");

  call_via_working_load_a: assert property (op_live && op_kind_i == PCS_OP_CALL_VIA_WORKING && !ovf_evt
    |=> pc_o == {$past(latch_reg), $past(op_wreg_i)})
    else $error("Working call target wrong");

  brw_target_a: assert property (op_live && op_kind_i == PCS_OP_BRW
    |=> pc_o == `PCS_PC_W'($past(pc_o) + 15'h0001 + {7'h00, $past(op_wreg_i)}))
    else $error("Working branch target wrong");

  bra_target_a: assert property (op_live && op_kind_i == PCS_OP_BRA
    |=> pc_o == `PCS_PC_W'($past(pc_o) + 15'h0001 +
      {{6{$past(op_operand_i[8])}}, $past(op_operand_i[8:0])}))
    else $error("Immediate branch target wrong");

  push_index_a: assert property (do_push && !ovf_evt
    |=> stack_index_o == `PCS_IDX_W'($past(idx_reg) + 5'h01))
    else $error("Push did not step index");

  empty_pop_a: assert property (do_pop && idx_reg == 5'h00
    |=> stack_index_o == `PCS_IDX_EMPTY)
    else $error("Pop from first entry not empty");

  fault_reset_a: assert property (fault_en_reg && (ovf_evt || unf_evt) |-> s_fault_seq)
    else $error("Fault reset sequence missing");

  wrap_push_a: assert property (!fault_en_reg && ovf_evt |-> s_wrap_seq)
    else $error("Stack did not wrap on overflow");

  flag_set_a: assert property (unf_evt |=> unf_reg)
    else $error("Underflow flag not set");

  latch_keep_a: assert property ((do_push || do_pop) && !wb_wr
    |=> latch_reg == $past(latch_reg))
    else $error("Push or pop changed latch");

  no_fault_a: assert property (!fault_en_reg |=> !fault_reset_o)
    else $error("Fault reset while disabled");

  push_data_a: assert property (do_push && !ovf_evt && op_kind_i == PCS_OP_CALL
    |=> tos_rd == $past(pc_inc))
    else $error("Call pushed wrong address");

  ////////////////////////////////////////////////////////////////////////////
  // Further guards on stack, flags, fault pulse, PC step, latch write and bus handshake

  ovf_flag_a: assert property (ovf_evt |=> ovf_reg)
    else $error("Overflow flag not set");

  ovf_sticky_a: assert property (ovf_reg && !(wb_wr && wb_hit_high &&
    wb_idx == `PCS_IDX_POWER && wb_dat_i[`PCS_BIT_OVF]) |=> ovf_reg)
    else $error("Overflow flag lost");

  unf_sticky_a: assert property (unf_reg && !(wb_wr && wb_hit_high &&
    wb_idx == `PCS_IDX_POWER && wb_dat_i[`PCS_BIT_UNF]) |=> unf_reg)
    else $error("Underflow flag lost");

  pop_index_a: assert property (do_pop && !unf_evt && idx_reg != 5'h00
    |=> stack_index_o == `PCS_IDX_W'($past(idx_reg) - 5'h01))
    else $error("Pop did not step index down");

  ret_load_a: assert property (do_pop && !(fault_en_reg && unf_evt)
    |=> pc_o == $past(tos_rd))
    else $error("Return did not load stack entry");

  unf_wrap_a: assert property (!fault_en_reg && unf_evt
    |=> stack_index_o == `PCS_IDX_UNF_WRAP)
    else $error("Underflow did not wrap index");

  vector_push_a: assert property (do_push && !ovf_evt && op_kind_i == PCS_OP_VECTOR
    |=> tos_rd == $past(pc_reg) && pc_o == `PCS_VECTOR)
    else $error("Vectoring pushed wrong address");

  call_via_working_push_a: assert property (do_push && !ovf_evt && op_kind_i == PCS_OP_CALL_VIA_WORKING
    |=> tos_rd == $past(pc_inc))
    else $error("Working call pushed wrong address");

  step_pc_a: assert property (op_live && op_kind_i == PCS_OP_STEP
    |=> pc_o == `PCS_PC_W'($past(pc_o) + 15'h0001))
    else $error("Step did not advance PC");

  latch_write_a: assert property (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_PC_LATCH
    |=> latch_reg == $past(wb_dat_i[6:0]))
    else $error("Latch write lost");

  index_write_a: assert property (wb_wr && wb_hit_high && wb_idx == `PCS_IDX_STACK_INDEX
    && !do_push && !do_pop && !fault_reg
    |=> stack_index_o == $past(wb_dat_i[`PCS_IDX_W-1:0]))
    else $error("Index write lost");

  fault_pulse_a: assert property (fault_reset_o |=> !fault_reset_o)
    else $error("Fault reset longer than one cycle");

  fault_flag_a: assert property (fault_reset_o |-> ovf_reg || unf_reg)
    else $error("Fault reset without flag");

  ack_follow_a: assert property (wb_req |=> wb_ack_o)
    else $error("Bus request not acknowledged");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held too long");

  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Ack without request");

  // Fault-enabled overflow must not move the stack index
  ovf_keep_a: assert property (fault_en_reg && ovf_evt
    |=> stack_index_o == $past(idx_reg))
    else $error("Fault overflow moved index");

endmodule : pcs_top

// ===== testbench/pcs_decoder_model.sv
`timescale 1ns/1ps
module pcs_decoder_model
  import pcs_pkg::*;
(
  input wire logic clk_i,
  output pcs_op_t op_kind_o,
  output logic [10:0] op_operand_o,
  output logic [7:0] op_wreg_o,
  output logic [7:0] op_result_o
);
  initial begin
    op_kind_o = PCS_OP_NONE;
    op_operand_o = 11'h000;
    op_wreg_o = 8'h00;
    op_result_o = 8'h00;
  end
  // One op held for exactly one taking edge; released operands flip to junk
  task automatic issue(input pcs_op_t k, input logic [10:0] opd, input logic [7:0] w);
    @(posedge clk_i);
    op_kind_o <= k;
    op_operand_o <= opd;
    op_wreg_o <= w;
    op_result_o <= w;
    @(posedge clk_i);
    op_kind_o <= PCS_OP_NONE;
    op_operand_o <= ~opd;
    op_wreg_o <= ~w;
    op_result_o <= ~w;
    #1;
  endtask : issue
endmodule : pcs_decoder_model

// ===== testbench/program_counter_and_return_stack_bench.sv
`timescale 1ns/1ps
`include "pcs_params.svh"
module program_counter_and_return_stack_bench import pcs_pkg::*; ();
  logic clk_i, rst_i, cyc, stb, we, ack, fault;
  logic [31:0] adr, dat_w, dat_r, rd;
  logic [3:0] sel;
  pcs_op_t op_kind;
  logic [10:0] op_operand;
  logic [7:0] op_wreg, op_result;
  logic [14:0] pc;
  logic [4:0] sidx;
  int fail_count, checks_done;
  //////////////////////////////////////////////////////////////////
  pcs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .op_kind_i(op_kind), .op_operand_i(op_operand), .op_wreg_i(op_wreg),
    .op_result_i(op_result), .pc_o(pc), .stack_index_o(sidx), .fault_reset_o(fault));
  pcs_decoder_model dec (.clk_i(clk_i), .op_kind_o(op_kind), .op_operand_o(op_operand),
    .op_wreg_o(op_wreg), .op_result_o(op_result));
  //////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {14'h0000, idx, 2'h0};
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rdchk(input string n, input logic [15:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0000_0000);
    chk(n, e, rd);
  endtask : rdchk
  task automatic pchk(input logic [14:0] p, input logic [4:0] i);
    chk("pc", 32'(p), 32'(pc));
    chk("index", 32'(i), 32'(sidx));
  endtask : pchk
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 32'h0000_0000;
    dat_w = 32'h0000_0000;
    sel = 4'hf;
    fail_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 pchk(15'h0000, 5'h1f);
    rdchk("index", `PCS_IDX_STACK_INDEX, 32'h0000_001f);
    bus(1'b1, `PCS_IDX_PC_LATCH, 32'h0000_0055);
    dec.issue(PCS_OP_WRITE_LOW, 11'h000, 8'h34);
    pchk(15'h5534, 5'h1f);
    rdchk("pc_low", `PCS_IDX_PC_LOW, 32'h0000_0034);
    dec.issue(PCS_OP_ADD_LOW, 11'h000, 8'hf0);
    pchk(15'h5524, 5'h1f);
    dec.issue(PCS_OP_CALL, 11'h123, 8'h00);
    pchk(15'h5123, 5'h00);
    rdchk("tos_low", `PCS_IDX_TOS_LOW, 32'h0000_0025);
    rdchk("tos_high", `PCS_IDX_TOS_HIGH, 32'h0000_0055);
    rdchk("latch", `PCS_IDX_PC_LATCH, 32'h0000_0055);
    dec.issue(PCS_OP_CALL_VIA_WORKING, 11'h000, 8'h77);
    pchk(15'h5577, 5'h01);
    dec.issue(PCS_OP_VECTOR, 11'h000, 8'h00);
    pchk(`PCS_VECTOR, 5'h02);
    dec.issue(PCS_OP_RET, 11'h000, 8'h00);
    pchk(15'h5577, 5'h01);
    dec.issue(PCS_OP_RET, 11'h000, 8'h00);
    pchk(15'h5124, 5'h00);
    dec.issue(PCS_OP_RET, 11'h000, 8'h00);
    pchk(15'h5525, 5'h1f);
    dec.issue(PCS_OP_BRW, 11'h000, 8'hf0);
    pchk(15'h5616, 5'h1f);
    dec.issue(PCS_OP_BRA, 11'h1f0, 8'h00);
    pchk(15'h5607, 5'h1f);
    dec.issue(PCS_OP_STEP, 11'h000, 8'h00);
    pchk(15'h5608, 5'h1f);
    bus(1'b1, `PCS_IDX_PC_LATCH, 32'h0000_007f);
    dec.issue(PCS_OP_WRITE_LOW, 11'h000, 8'hff);
    dec.issue(PCS_OP_BRW, 11'h000, 8'h02);
    pchk(15'h0002, 5'h1f);
    // Sixteen pushes fill the stack without a fault
    for (int i = 0; i < 16; i++) dec.issue(PCS_OP_CALL, 11'(i), 8'h00);
    pchk(15'h780f, 5'h0f);
    rdchk("power", `PCS_IDX_POWER, 32'h0000_0000);
    dec.issue(PCS_OP_CALL, 11'h050, 8'h00);
    pchk(15'h7850, 5'h00);
    rdchk("tos_low", `PCS_IDX_TOS_LOW, 32'h0000_0010);
    rdchk("power", `PCS_IDX_POWER, 32'h0000_0002);
    bus(1'b1, `PCS_IDX_POWER, 32'h0000_0003);
    dec.issue(PCS_OP_RET, 11'h000, 8'h00);
    dec.issue(PCS_OP_RET, 11'h000, 8'h00);
    chk("index", 32'h0000_000e, 32'(sidx));
    rdchk("power", `PCS_IDX_POWER, 32'h0000_0001);
    bus(1'b1, `PCS_IDX_POWER, 32'h0000_0003);
    // Index moved by software only while no vectoring is pending
    bus(1'b1, `PCS_IDX_STACK_INDEX, 32'h0000_0003);
    bus(1'b1, `PCS_IDX_TOS_LOW, 32'h0000_00ab);
    bus(1'b1, `PCS_IDX_TOS_HIGH, 32'h0000_0012);
    rdchk("tos_low", `PCS_IDX_TOS_LOW, 32'h0000_00ab);
    rdchk("tos_high", `PCS_IDX_TOS_HIGH, 32'h0000_0012);
    bus(1'b1, `PCS_IDX_STACK_INDEX, 32'h0000_00ff);
    rdchk("index", `PCS_IDX_STACK_INDEX, 32'h0000_001f);
    rdchk("unmapped", 16'h1fec, 32'h0000_0000);
    bus(1'b1, `PCS_IDX_CONFIG, 32'h0000_0001);
    dec.issue(PCS_OP_RET, 11'h000, 8'h00);
    chk("fault", 32'h0000_0001, 32'(fault));
    @(posedge clk_i);
    #1 pchk(15'h0000, 5'h1f);
    rdchk("power", `PCS_IDX_POWER, 32'h0000_0001);
    wrap_up();
  end
endmodule : program_counter_and_return_stack_bench
